/* File: hw/spc_pkg.sv */
package spc_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses on the slave bus
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_IRQ_EN  = 8'h04;
    localparam logic [7:0]  OFF_FLAGS   = 8'h08;
    localparam logic [7:0]  OFF_PINCTL  = 8'h0C;
    localparam logic [1:0]  RAM_SEL     = 2'h1;
    localparam int          RAM_WORDS   = 16;

    // ----------------------------------------------------------------
    // field positions and codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  SRC_SLEEP   = 3'h6;
    localparam logic [2:0]  SRC_STATIC  = 3'h7;
    localparam int          EV_ALARM    = 0;
    localparam int          EV_TIMER    = 1;
    localparam int          EV_EXT      = 2;
    localparam int          EV_CMP      = 3;
    localparam int          EV_FAIL     = 4;
    localparam int          NUM_EV      = 5;
    localparam int          FLG_SLEEP   = 5;
    localparam int          FLG_EXTPIN  = 8;
    localparam int          FLG_CMPPIN  = 9;
    localparam int          FLG_ASLEEP  = 10;
    localparam int          SYNC_BITS   = 2;

    // ----------------------------------------------------------------
    // register layouts, bit 0 at the right
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       stop;
        logic       switch_lock;
        logic       static_switch_level;
        logic [2:0] switch_source_select;
        logic       switch_drive_config;
        logic       sleep_reset_enable;
        logic       sleep_request;
    } spc_ctrl_t;

    typedef struct packed {
        logic       timer_run;
        logic       cmp_falling;
        logic       fail_ie;
        logic       cmp_ie;
        logic       ext_ie;
        logic       timer_ie;
        logic       alarm_ie;
    } spc_irq_en_t;

    typedef struct packed {
        logic       bus_pins_disable;
        logic       wake_input_disable;
        logic       rst_sleep_keep;
        logic       clk_sleep_keep;
    } spc_pinctl_t;

    typedef struct packed {
        logic       failure;
        logic       timer;
        logic       alarm;
    } spc_evt_t;

    localparam logic [8:0]  CTRL_RST    = 9'h0B8;
    localparam logic [6:0]  IRQ_EN_RST  = 7'h00;
    localparam logic [3:0]  PINCTL_RST  = 4'h3;

    typedef enum logic [2:0] {
        ST_AWAKE = 3'b001,
        ST_WAIT  = 3'b010,
        ST_SLEEP = 3'b100
    } spc_state_t;

endpackage : spc_pkg

/* File: hw/spc_sync.sv */
`timescale 1ns/1ns
module spc_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // pins in, levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    // ----------------------------------------------------------------
    // two flops per pin; first flop feeds only the second
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    meta_q       <= 1'b0;
                    level_out[i] <= 1'b0;
                end else begin
                    meta_q       <= pin_in[i];
                    level_out[i] <= meta_q;
                end
            end
        end
    endgenerate

endmodule : spc_sync

/* File: hw/spc_top.sv */
`timescale 1ns/1ns
module spc_top (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         reset,
    // avalon-mm slave
    input  wire logic [spc_pkg::ADDR_W-1:0]   address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [spc_pkg::DATA_W-1:0]   writedata,
    input  wire logic [3:0]                   byteenable,
    output logic      [spc_pkg::DATA_W-1:0]   readdata,
    output logic                              waitrequest,
    // wake sources
    input  wire spc_pkg::spc_evt_t            wake_event,
    input  wire logic                         external_wake_input,
    input  wire logic                         comparator_level,
    // power switch pin, open drain when configured
    output logic                              power_switch_output,
    output logic                              power_switch_oe_n,
    // host reset pin
    output logic                              host_reset_n,
    output logic                              host_reset_oe_n,
    // host interrupt pin
    output logic                              host_int_n,
    output logic                              host_int_oe_n,
    // serial bus pin gating
    output logic                              bus_pins_off
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    spc_pkg::spc_ctrl_t                 ctrl_q;
    spc_pkg::spc_irq_en_t               irq_en_q;
    spc_pkg::spc_pinctl_t               pinctl_q;
    spc_pkg::spc_state_t                state_q;
    logic [spc_pkg::NUM_EV-1:0]         flags_q;
    logic                               sleep_flag_q;
    logic [spc_pkg::DATA_W-1:0]         ram_q [spc_pkg::RAM_WORDS];
    logic                               ack_q;
    logic [spc_pkg::DATA_W-1:0]         readdata_q;
    logic [1:0]                         pins_s;
    logic                               ext_s;
    logic                               cmp_s;
    logic                               ext_prev_q;
    logic                               cmp_prev_q;
    logic [spc_pkg::NUM_EV-1:0]         ev_set;
    logic [spc_pkg::NUM_EV-1:0]         ev_en;
    logic                               pending;
    logic                               wake_source_armed;
    logic                               asleep;
    logic                               wr_go;
    logic                               rd_go;
    logic                               sel_ram;
    logic [3:0]                         ram_idx;
    logic [spc_pkg::DATA_W-1:0]         wmask;
    logic [spc_pkg::DATA_W-1:0]         wdata_m;
    logic                               psw_level;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    spc_sync #(.WIDTH(spc_pkg::SYNC_BITS)) u_sync (
        .mclk      (mclk),
        .reset     (reset),
        .pin_in    ({comparator_level, external_wake_input}),
        .level_out (pins_s)
    );
    assign ext_s = pins_s[0];
    assign cmp_s = pins_s[1];

    // ----------------------------------------------------------------
    // bus decode: one wait cycle, then accept
    // ----------------------------------------------------------------
    assign waitrequest = (read | write) & ~ack_q;
    assign wr_go       = write & ack_q;
    assign rd_go       = read & ~ack_q;
    assign sel_ram     = address[7:6] == spc_pkg::RAM_SEL;
    assign ram_idx     = address[5:2];
    assign readdata    = readdata_q;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{byteenable[b]}};
        end
        wdata_m = writedata & wmask;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read | write) & ~ack_q;
        end
    end

    // ----------------------------------------------------------------
    // wake events and pending interrupt
    // ----------------------------------------------------------------
    assign asleep = state_q == spc_pkg::ST_SLEEP;

    always_comb begin
        ev_set                    = '0;
        ev_set[spc_pkg::EV_ALARM] = wake_event.alarm;
        ev_set[spc_pkg::EV_TIMER] = wake_event.timer;
        // disabled wake input is ignored while asleep
        ev_set[spc_pkg::EV_EXT]   = ext_s & ~ext_prev_q
                                    & ~(asleep & pinctl_q.wake_input_disable);
        ev_set[spc_pkg::EV_CMP]   = irq_en_q.cmp_falling ? (cmp_prev_q & ~cmp_s)
                                                          : (cmp_s & ~cmp_prev_q);
        ev_set[spc_pkg::EV_FAIL]  = wake_event.failure;
        ev_en                     = '0;
        ev_en[spc_pkg::EV_ALARM]  = irq_en_q.alarm_ie;
        ev_en[spc_pkg::EV_TIMER]  = irq_en_q.timer_ie & irq_en_q.timer_run;
        ev_en[spc_pkg::EV_EXT]    = irq_en_q.ext_ie;
        ev_en[spc_pkg::EV_CMP]    = irq_en_q.cmp_ie;
        ev_en[spc_pkg::EV_FAIL]   = irq_en_q.fail_ie;
    end

    assign pending           = |(flags_q & ev_en);
    assign wake_source_armed = |ev_en;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ext_prev_q <= 1'b0;
            cmp_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_s;
            cmp_prev_q <= cmp_s;
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags_q <= '0;
        end else if (wr_go && address == spc_pkg::OFF_FLAGS) begin
            flags_q <= (flags_q & ~wdata_m[spc_pkg::NUM_EV-1:0]) | ev_set;
        end else begin
            flags_q <= flags_q | ev_set;
        end
    end

    // ----------------------------------------------------------------
    // sleep sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= spc_pkg::ST_AWAKE;
        end else begin
            case (state_q)
                spc_pkg::ST_AWAKE: begin
                    if (ctrl_q.sleep_request) begin
                        state_q <= spc_pkg::ST_WAIT;
                    end
                end
                spc_pkg::ST_WAIT: begin
                    // a trigger before sleep aborts the entry
                    state_q <= pending ? spc_pkg::ST_AWAKE : spc_pkg::ST_SLEEP;
                end
                spc_pkg::ST_SLEEP: begin
                    if (pending) begin
                        state_q <= spc_pkg::ST_AWAKE;
                    end
                end
                default: state_q <= spc_pkg::ST_AWAKE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sleep_flag_q <= 1'b0;
        end else if (state_q == spc_pkg::ST_WAIT && !pending) begin
            sleep_flag_q <= 1'b1;
        end else if (wr_go && address == spc_pkg::OFF_FLAGS && byteenable[0]
                     && writedata[spc_pkg::FLG_SLEEP]) begin
            sleep_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= spc_pkg::CTRL_RST;
        end else begin
            if (wr_go && address == spc_pkg::OFF_CTRL && byteenable[0]) begin
                ctrl_q.sleep_reset_enable   <= writedata[1];
                ctrl_q.switch_drive_config  <= writedata[2];
                ctrl_q.switch_source_select <= writedata[5:3];
                ctrl_q.switch_lock          <= writedata[7];
                // raising the static level needs the lock clear first
                if (!writedata[6] || !ctrl_q.switch_lock) begin
                    ctrl_q.static_switch_level <= writedata[6];
                end
                // refused while stopped, unarmed or pending
                if (writedata[0] && !ctrl_q.stop && wake_source_armed && !pending) begin
                    ctrl_q.sleep_request <= 1'b1;
                end else if (!writedata[0]) begin
                    ctrl_q.sleep_request <= 1'b0;
                end
            end
            if (wr_go && address == spc_pkg::OFF_CTRL && byteenable[1]) begin
                ctrl_q.stop <= writedata[8];
            end
            if ((state_q == spc_pkg::ST_WAIT && pending)
                || (asleep && pending)) begin
                ctrl_q.sleep_request <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_en_q <= spc_pkg::IRQ_EN_RST;
            pinctl_q <= spc_pkg::PINCTL_RST;
        end else if (wr_go && byteenable[0]) begin
            if (address == spc_pkg::OFF_IRQ_EN) begin
                irq_en_q <= writedata[6:0];
            end
            if (address == spc_pkg::OFF_PINCTL) begin
                pinctl_q <= writedata[3:0];
            end
        end
    end

    // user memory has no state gating at all
    always_ff @(posedge mclk) begin
        if (wr_go && sel_ram) begin
            ram_q[ram_idx] <= (ram_q[ram_idx] & ~wmask) | wdata_m;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            readdata_q <= '0;
        end else if (rd_go) begin
            readdata_q <= '0;
            if (sel_ram) begin
                readdata_q <= ram_q[ram_idx];
            end else begin
                case (address)
                    spc_pkg::OFF_CTRL:   readdata_q[8:0] <= ctrl_q;
                    spc_pkg::OFF_IRQ_EN: readdata_q[6:0] <= irq_en_q;
                    spc_pkg::OFF_PINCTL: readdata_q[3:0] <= pinctl_q;
                    spc_pkg::OFF_FLAGS: begin
                        readdata_q[spc_pkg::NUM_EV-1:0]  <= flags_q;
                        readdata_q[spc_pkg::FLG_SLEEP]   <= sleep_flag_q;
                        readdata_q[spc_pkg::FLG_EXTPIN]  <= ext_s;
                        readdata_q[spc_pkg::FLG_CMPPIN]  <= cmp_s;
                        readdata_q[spc_pkg::FLG_ASLEEP]  <= asleep;
                    end
                    default: readdata_q <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drivers, registered so the switch never glitches
    // ----------------------------------------------------------------
    always_comb begin
        case (ctrl_q.switch_source_select)
            spc_pkg::SRC_SLEEP:  psw_level = asleep;
            spc_pkg::SRC_STATIC: psw_level = ctrl_q.static_switch_level;
            default:             psw_level = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            power_switch_output <= 1'b0;
            power_switch_oe_n   <= 1'b0;
        end else if (ctrl_q.switch_drive_config) begin
            // open drain: pulled to ground closed, released open
            power_switch_output <= 1'b0;
            power_switch_oe_n   <= psw_level;
        end else begin
            power_switch_output <= psw_level;
            power_switch_oe_n   <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            host_reset_n    <= 1'b1;
            host_reset_oe_n <= 1'b0;
            host_int_n      <= 1'b1;
            host_int_oe_n   <= 1'b0;
            bus_pins_off    <= 1'b0;
        end else begin
            // pushed high when awake so no pull-up is needed
            host_reset_n    <= ~(asleep & ctrl_q.sleep_reset_enable);
            host_reset_oe_n <= asleep & ~pinctl_q.rst_sleep_keep;
            host_int_n      <= ~pending;
            host_int_oe_n   <= asleep & ~pinctl_q.clk_sleep_keep;
            bus_pins_off    <= asleep & pinctl_q.bus_pins_disable;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    switch_opens_a: assert property (
        asleep && ctrl_q.switch_drive_config
            && ctrl_q.switch_source_select == spc_pkg::SRC_SLEEP
        |=> power_switch_oe_n && !power_switch_output)
        else $error("switch not open in sleep");

    reset_default_a: assert property (
        $past(reset) |-> ctrl_q.switch_source_select == spc_pkg::SRC_STATIC
            && !ctrl_q.static_switch_level && !power_switch_oe_n)
        else $error("switch source wrong after reset");

    sleep_reset_a: assert property (
        asleep && ctrl_q.sleep_reset_enable |=> !host_reset_n)
        else $error("host reset not low in sleep");

    wake_release_a: assert property (
        asleep && pending |=> !asleep && !ctrl_q.sleep_request ##1 host_reset_n)
        else $error("wake did not release host");

    int_assert_a: assert property (
        (flags_q[spc_pkg::EV_ALARM] && irq_en_q.alarm_ie) |=> !host_int_n)
        else $error("interrupt output not asserted");

    pin_read_a: assert property (
        rd_go && !sel_ram && address == spc_pkg::OFF_FLAGS
        |=> readdata_q[spc_pkg::FLG_EXTPIN] == $past(ext_s))
        else $error("wake pin level not readable");

    cmp_edge_a: assert property (
        irq_en_q.cmp_falling && $fell(cmp_s) |=> flags_q[spc_pkg::EV_CMP])
        else $error("comparator falling edge lost");

    fail_wake_a: assert property (
        asleep && wake_event.failure && irq_en_q.fail_ie |-> ##[1:2] !asleep)
        else $error("failure did not wake");

    sleep_guard_a: assert property (
        $rose(ctrl_q.sleep_request)
        |-> $past(!ctrl_q.stop && wake_source_armed && !pending))
        else $error("sleep request set while refused");

    sleep_flag_a: assert property (
        state_q == spc_pkg::ST_WAIT && !pending |=> asleep && sleep_flag_q)
        else $error("sleep flag not set on entry");

    switch_lock_a: assert property (
        $rose(ctrl_q.static_switch_level) |-> !$past(ctrl_q.switch_lock))
        else $error("static level raised while locked");

endmodule : spc_top

/* File: testbench/spc_host_model.sv */
`timescale 1ns/1ns
module spc_host_model (
    // pins from the block
    input  wire logic mclk,
    input  wire logic power_switch_oe_n,
    input  wire logic host_reset_n,
    input  wire logic host_reset_oe_n,
    // host status
    output logic      host_awake
);
    logic rst_last_q;
    logic rst_wire;
    // reset line has no pull-up, so a released line shows no stable level
    assign rst_wire = host_reset_oe_n ? ~rst_last_q : host_reset_n;
    always_ff @(posedge mclk) begin
        rst_last_q <= rst_wire;
    end
    // host runs only with its ground switch closed and reset high
    assign host_awake = ~power_switch_oe_n & rst_wire;
endmodule : spc_host_model

/* File: testbench/sleep_power_switch_control_tb_top.sv */
`timescale 1ns/1ns
module sleep_power_switch_control_tb_top;
    logic              mclk, reset, read, write, waitrequest, ext_in, cmp_in, host_awake;
    logic              psw_out, psw_oe_n, rst_n, rst_oe_n, int_n, int_oe_n, bus_off;
    logic [7:0]        address;
    logic [3:0]        byteenable;
    logic [31:0]       writedata, readdata, q;
    spc_pkg::spc_evt_t wake_event;
    int                num_errors, cmp_count, cyc, ctrl_m, ien_m, n, pend_m;
    int                ram_m[$];
    // enables per source: alarm, timer with run, ext, falling comparator, fail
    int                ien_tab[5] = '{32'h01, 32'h42, 32'h04, 32'h28, 32'h10};

    spc_top uut (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .wake_event(wake_event), .external_wake_input(ext_in),
        .comparator_level(cmp_in), .power_switch_output(psw_out),
        .power_switch_oe_n(psw_oe_n), .host_reset_n(rst_n), .host_reset_oe_n(rst_oe_n),
        .host_int_n(int_n), .host_int_oe_n(int_oe_n), .bus_pins_off(bus_off));
    spc_host_model host (.mclk(mclk), .power_switch_oe_n(psw_oe_n), .host_reset_n(rst_n),
        .host_reset_oe_n(rst_oe_n), .host_awake(host_awake));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // a new request starts an edge after the last one is released
    // no local limit: only the cycle ceiling ends a hung wait
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    // control writes pass through the mirror first
    task automatic wr_ctrl(input int d);
        int nv = d & 32'h1FF;
        if ((ctrl_m & 32'h80) && !(ctrl_m & 32'h40)) nv &= ~32'h40;
        // stop is judged by its value before this write, as is pending
        if ((nv & 1) && !(ctrl_m & 1) && ((ctrl_m & 32'h100) || pend_m
            || !((ien_m & 32'h1D) || (ien_m & 32'h42) == 32'h42))) nv &= ~1;
        ctrl_m = nv;
        bus(1'b1, 8'h00, 32'(d));
    endtask : wr_ctrl

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        wake_event = '0;
        ext_in = 1'b0;
        cmp_in = 1'b1;
        ctrl_m = 32'h0B8;
        n = $urandom(32'he8ae);
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        chk(32'(psw_oe_n), 32'h0);
        rd(8'h00, ctrl_m);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h3);
        rd(8'h20, 32'h0);
        wr_ctrl(32'hF8);
        rd(8'h00, ctrl_m);
        wr_ctrl(32'h38);
        wr_ctrl(32'h78);
        rd(8'h00, ctrl_m);
        wr_ctrl(32'hB8);
        wr_ctrl(32'hB6);
        wr_ctrl(32'hB7);
        rd(8'h00, ctrl_m);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            ram_m.push_back($urandom);
            bus(1'b1, 8'(64 + 4 * i), ram_m[i]);
        end
        bus(1'b1, 8'h0C, 32'hB);
        for (int e = 0; e < 5; e++) begin
            ien_m = ien_tab[e];
            bus(1'b1, 8'h04, ien_m);
            if (e == 0) begin
                // refused while an enabled flag is pending, then while stopped
                wake_event <= spc_pkg::spc_evt_t'(3'h1);
                @(posedge mclk);
                wake_event <= '0;
                pend_m = 1;
                wr_ctrl(32'hB7);
                rd(8'h00, ctrl_m);
                pend_m = 0;
                wr_ctrl(32'h1B6);
                wr_ctrl(32'h1B7);
                rd(8'h00, ctrl_m);
                wr_ctrl(32'hB6);
            end
            bus(1'b1, 8'h08, 32'h3F);
            wr_ctrl(32'hB7);
            n = 0;
            do begin
                bus(1'b0, 8'h08, 32'h0);
                n++;
            end while (q[10] !== 1'b1 && n < 20);
            chk(q & 32'h43F, 32'h420);
            chk({psw_oe_n, rst_n, bus_off, host_awake}, 4'b1010);
            chk({psw_out, rst_oe_n, int_oe_n}, 3'b000);
            rd(8'(64 + 4 * e), ram_m[e]);
            if (e == 2)
                ext_in <= 1'b1;
            else if (e == 3)
                cmp_in <= 1'b0;
            else
                wake_event <= spc_pkg::spc_evt_t'(3'(1 << (e == 4 ? 2 : e)));
            @(posedge mclk);
            wake_event <= '0;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (psw_oe_n !== 1'b0 && n < 30);
            ctrl_m &= ~1;
            chk({psw_oe_n, rst_n, bus_off, host_awake, int_n}, 5'b01010);
            rd(8'h08, (1 << e) | 32'h20 | (e == 2 ? 32'h100 : 0)
                | (e == 3 ? 0 : 32'h200));
            rd(8'h00, ctrl_m);
            ext_in <= 1'b0;
            cmp_in <= 1'b1;
            repeat (5) @(posedge mclk);
            $display("test wake source %0d done", e);
        end
        end_sim();
    end
endmodule : sleep_power_switch_control_tb_top
